// *** inc/tcp_pkg.sv ***
`default_nettype none
package tcp_pkg;
  // Clock rate and timing
  localparam int unsigned CLK_MHZ      = 125;
  localparam int unsigned PA_LEAD_NS   = 5000;
  localparam int unsigned PA_LEAD_CYC  = (PA_LEAD_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned RUN_MAX_NS   = 3000;
  localparam int unsigned RUN_MAX_CYC  = (RUN_MAX_NS * CLK_MHZ) / 1000;

  // Serial word layout
  localparam int unsigned SER_WORD_W   = 16;
  localparam int unsigned SER_ADDR_W   = 2;
  localparam int unsigned SER_DATA_W   = 14;
  localparam int unsigned SER_ADDR_LSB = 14;
  localparam int unsigned SER_NREG     = 4;

  // Control register 0 fields
  localparam int unsigned R0_TPC_MODE_BIT  = 6;
  localparam int unsigned R0_TPC_BIT       = 7;
  localparam int unsigned R0_INTERLOCK_BIT = 8;
  localparam logic [13:0] CTRL_RST         = 14'h0000;
  localparam logic        TPC_LVL_RST      = 1'b1;

  // Wishbone byte offsets
  localparam logic [7:0] WB_CTRL0  = 8'h00;
  localparam logic [7:0] WB_CTRL1  = 8'h04;
  localparam logic [7:0] WB_CTRL2  = 8'h08;
  localparam logic [7:0] WB_CTRL3  = 8'h0c;
  localparam logic [7:0] WB_STATUS = 8'h10;
  localparam logic [7:0] WB_CONFIG = 8'h14;
  localparam logic [7:0] WB_EVENTS = 8'h18;

  // Status, event and config fields
  localparam int unsigned ST_POWER_BIT = 0;
  localparam int unsigned ST_RX_BIT    = 1;
  localparam int unsigned ST_TX_BIT    = 2;
  localparam int unsigned ST_RF_BIT    = 3;
  localparam int unsigned ST_PA_BIT    = 4;
  localparam int unsigned ST_LOCK_BIT  = 5;
  localparam int unsigned ST_TPC_BIT   = 6;
  localparam int unsigned EV_RUN_BIT   = 0;
  localparam int unsigned EV_WORD_BIT  = 1;
  localparam logic [15:0] SETTLE_RST   = 16'h0010;

  typedef enum logic [1:0] {
    PA_OFF,
    PA_SETTLE,
    PA_ON,
    PA_TAIL
  } tcp_pa_state_t;

  typedef struct packed {
    logic                  valid;
    logic [SER_ADDR_W-1:0] addr;
    logic [SER_DATA_W-1:0] data;
  } tcp_ser_word_t;
endpackage
`default_nettype wire

// *** logic/tcp_serial_rx.sv ***
`timescale 1ns/1ps
`default_nettype none
module tcp_serial_rx (
  input  wire logic           i_mclk,
  input  wire logic           i_nrst,
  input  wire logic           i_ser_clk,
  input  wire logic           i_ser_data,
  input  wire logic           i_ser_en,
  output tcp_pkg::tcp_ser_word_t o_word
);
  typedef struct packed {
    logic        clk_s1;
    logic        clk_s2;
    logic        clk_d;
    logic        dat_s1;
    logic        dat_s2;
    logic        en_s1;
    logic        en_s2;
    logic        en_d;
    logic [15:0] shift;
    tcp_pkg::tcp_ser_word_t word;
  } tcp_ser_state_t;

  tcp_ser_state_t st_r;
  tcp_ser_state_t st_nxt;

  // Rising edge of a synchronised level
  function automatic logic tcp_rise(input logic now, input logic was);
    tcp_rise = now & ~was;
  endfunction

  // Shift on rising clock edges while enable low, latch on enable rise
  always_comb begin
    st_nxt            = st_r;
    st_nxt.clk_s1     = i_ser_clk;
    st_nxt.clk_s2     = st_r.clk_s1;
    st_nxt.clk_d      = st_r.clk_s2;
    st_nxt.dat_s1     = i_ser_data;
    st_nxt.dat_s2     = st_r.dat_s1;
    st_nxt.en_s1      = i_ser_en;
    st_nxt.en_s2      = st_r.en_s1;
    st_nxt.en_d       = st_r.en_s2;
    st_nxt.word.valid = 1'b0;
    if (!st_r.en_s2 && tcp_rise(st_r.clk_s2, st_r.clk_d)) begin // RULE_09
      st_nxt.shift = {st_r.shift[14:0], st_r.dat_s2}; // RULE_16
    end
    if (tcp_rise(st_r.en_s2, st_r.en_d)) begin // RULE_06
      st_nxt.word.valid = 1'b1; // RULE_10
      st_nxt.word.addr  = st_r.shift[15:tcp_pkg::SER_ADDR_LSB]; // RULE_16
      st_nxt.word.data  = st_r.shift[tcp_pkg::SER_DATA_W-1:0];
    end
  end

  // State register; shifting frozen while enable is high
  always_ff @(posedge i_mclk or negedge i_nrst) begin // RULE_07
    if (!i_nrst) begin
      st_r       <= '0;
      // Enable idles high; matching it avoids a false latch after reset
      st_r.en_s1 <= 1'b1;
      st_r.en_s2 <= 1'b1;
      st_r.en_d  <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_word = st_r.word;
endmodule
`default_nettype wire

// *** logic/tcp_slicer.sv ***
`timescale 1ns/1ps
`default_nettype none
module tcp_slicer #(
  parameter int unsigned W = 8
) (
  input  wire logic         i_mclk,
  input  wire logic         i_nrst,
  input  wire logic         i_active,
  input  wire logic [W-1:0] i_demod,
  output logic              o_bit,
  output logic              o_run_long
);
  typedef struct packed {
    logic [W+3:0] mean;
    logic         bit_v;
    logic [9:0]   run;
    logic         run_long;
  } tcp_slc_state_t;

  tcp_slc_state_t st_r;
  tcp_slc_state_t st_nxt;
  logic [W+3:0]   scaled;

  // Centre tracks sixteen times the mean; bit is sample above centre
  always_comb begin
    scaled          = {i_demod, 4'h0};
    st_nxt          = st_r;
    st_nxt.run_long = 1'b0;
    st_nxt.mean     = st_r.mean - (st_r.mean >> 4) + {4'h0, i_demod};
    if (!i_active) begin
      st_nxt.bit_v = 1'b0;
      st_nxt.run   = 10'h000;
    end else begin
      st_nxt.bit_v = scaled > st_r.mean; // RULE_15
      if (st_nxt.bit_v != st_r.bit_v) begin
        st_nxt.run = 10'h000;
      end else if (st_r.run != 10'h3ff) begin
        st_nxt.run = st_r.run + 10'h001;
      end
      // Flag a run at the slicer's length limit
      st_nxt.run_long = (st_nxt.run == 10'(tcp_pkg::RUN_MAX_CYC)); // RULE_15
    end
  end

  // State register
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_bit      = st_r.bit_v;
  assign o_run_long = st_r.run_long;
endmodule
`default_nettype wire

// *** logic/tcp_top.sv ***
// Function
// RULE_01 - Enable high powers up, low is standby
// RULE_02 - Select input switches transmit and receive paths
// RULE_03 - Enabled: select high receive, low transmit
// RULE_04 - PA enable with RF, drops 5us before
// RULE_05 - Interlock holds PA off while PLL unlocked
// RULE_06 - Enable rising edge latches word into register
// RULE_07 - Serial activity ignored while enable high
// RULE_08 - Controller sends 16-bit words with address
// RULE_09 - Data sampled on clock rise, enable low
// RULE_10 - No error checking of latched words
// RULE_11 - Serial bus and registers live in standby
// RULE_12 - Power-control mode: open drain low when bit zero
// RULE_13 - Power-control level changes on select falling edge
// RULE_14 - Transmit data input becomes FSK modulation
// RULE_15 - Centre slicer, runs under 3us only
// RULE_16 - Last sixteen bits, address picks register
`timescale 1ns/1ps
`default_nettype none
module tcp_top #(
  parameter int unsigned DEMOD_W = 8
) (
  input  wire logic               i_mclk,
  input  wire logic               i_nrst,
  input  wire logic               i_wb_cyc,
  input  wire logic               i_wb_stb,
  input  wire logic               i_wb_we,
  input  wire logic [7:0]         i_wb_adr,
  input  wire logic [31:0]        i_wb_dat,
  input  wire logic [3:0]         i_wb_sel,
  output logic [31:0]             o_wb_dat,
  output logic                    o_wb_ack,
  input  wire logic               i_transceiver_enable,
  input  wire logic               i_rx_tx_select,
  input  wire logic               i_ser_clk,
  input  wire logic               i_ser_data,
  input  wire logic               i_ser_en,
  input  wire logic               i_tx_data,
  input  wire logic               i_pll_lock,
  input  wire logic [DEMOD_W-1:0] i_demod,
  output logic                    o_power_on,
  output logic                    o_rx_active,
  output logic                    o_tx_active,
  output logic                    o_tx_mod_bit,
  output logic                    o_rf_tx_output_on,
  output logic                    o_pa_enable_out,
  output logic                    o_power_ctl_out_o,
  output logic                    o_power_ctl_out_oe,
  output logic                    o_rx_data
);
  typedef struct packed {
    logic                  transceiver_enable_s1;
    logic                  transceiver_enable_s2;
    logic                  rxs_s1;
    logic                  rxs_s2;
    logic                  rxs_d;
    logic                  din_s1;
    logic                  din_s2;
    logic                  lock_s1;
    logic                  lock_s2;
    logic [3:0][13:0]      ctrl;
    tcp_pkg::tcp_pa_state_t pa_st;
    logic [15:0]           pa_cnt;
    logic                  rf_on;
    logic                  pa_en;
    logic                  tpc_lvl;
    logic                  od_oe;
    logic                  power_on;
    logic                  rx_act;
    logic                  tx_act;
    logic                  tx_mod;
    logic                  rx_bit;
    logic [15:0]           settle;
    logic [1:0]            ev;
    logic                  ack;
    logic [31:0]           dat;
  } tcp_top_state_t;

  tcp_top_state_t         st_r;
  tcp_top_state_t         st_nxt;
  tcp_pkg::tcp_ser_word_t ser_word;
  logic                   slc_bit;
  logic                   slc_run_long;
  logic                   tx_mode;
  logic                   rx_mode;
  logic                   pa_block;
  logic                   wb_req;
  logic                   wb_wr;
  logic [31:0]            status;
  logic [1:0]             ev_set;
  logic [1:0]             ev_clr;

  // Serial bus receiver, powered regardless of standby
  tcp_serial_rx u_ser ( // RULE_11
    .i_mclk     (i_mclk),
    .i_nrst     (i_nrst),
    .i_ser_clk  (i_ser_clk),
    .i_ser_data (i_ser_data),
    .i_ser_en   (i_ser_en),
    .o_word     (ser_word)
  );

  // Receive data slicer, active only in receive mode
  tcp_slicer #(
    .W (DEMOD_W)
  ) u_slc (
    .i_mclk     (i_mclk),
    .i_nrst     (i_nrst),
    .i_active   (st_r.rx_act),
    .i_demod    (i_demod),
    .o_bit      (slc_bit),
    .o_run_long (slc_run_long)
  );

  // Operating mode from synchronised pins
  always_comb begin
    rx_mode  = st_r.transceiver_enable_s2 & st_r.rxs_s2; // RULE_03
    tx_mode  = st_r.transceiver_enable_s2 & ~st_r.rxs_s2; // RULE_03
    pa_block = st_r.ctrl[0][tcp_pkg::R0_INTERLOCK_BIT] & ~st_r.lock_s2;
    wb_req   = i_wb_cyc & i_wb_stb & ~st_r.ack;
    wb_wr    = wb_req & i_wb_we;
  end

  // Status word for software
  always_comb begin
    status                        = 32'h0000_0000;
    status[tcp_pkg::ST_POWER_BIT] = st_r.power_on;
    status[tcp_pkg::ST_RX_BIT]    = st_r.rx_act;
    status[tcp_pkg::ST_TX_BIT]    = st_r.tx_act;
    status[tcp_pkg::ST_RF_BIT]    = st_r.rf_on;
    status[tcp_pkg::ST_PA_BIT]    = st_r.pa_en;
    status[tcp_pkg::ST_LOCK_BIT]  = st_r.lock_s2;
    status[tcp_pkg::ST_TPC_BIT]   = st_r.tpc_lvl;
  end

  // Event set and write-one clear terms
  always_comb begin
    ev_set                       = 2'h0;
    ev_set[tcp_pkg::EV_RUN_BIT]  = slc_run_long;
    ev_set[tcp_pkg::EV_WORD_BIT] = ser_word.valid;
    ev_clr                       = 2'h0;
    if (wb_wr && i_wb_adr == tcp_pkg::WB_EVENTS && i_wb_sel[0]) begin
      ev_clr = i_wb_dat[1:0];
    end
  end

  // Next state
  always_comb begin
    st_nxt         = st_r;
    st_nxt.transceiver_enable_s1 = i_transceiver_enable;
    st_nxt.transceiver_enable_s2 = st_r.transceiver_enable_s1;
    st_nxt.rxs_s1  = i_rx_tx_select;
    st_nxt.rxs_s2  = st_r.rxs_s1;
    st_nxt.rxs_d   = st_r.rxs_s2;
    st_nxt.din_s1  = i_tx_data;
    st_nxt.din_s2  = st_r.din_s1;
    st_nxt.lock_s1 = i_pll_lock;
    st_nxt.lock_s2 = st_r.lock_s1;

    // Power and path enables
    st_nxt.power_on = st_r.transceiver_enable_s2; // RULE_01
    st_nxt.rx_act   = rx_mode; // RULE_02
    st_nxt.tx_act   = tx_mode; // RULE_02

    // Transmit data follows the pin's own timing
    st_nxt.tx_mod = tx_mode & st_r.din_s2; // RULE_14
    st_nxt.rx_bit = slc_bit; // RULE_15

    // Latched serial word, taken as is, in any mode
    if (ser_word.valid) begin // RULE_10
      st_nxt.ctrl[ser_word.addr] = ser_word.data; // RULE_16
    end

    // Power-control level moves only on receive-to-transmit edge
    if (st_r.rxs_d && !st_r.rxs_s2) begin // RULE_13
      st_nxt.tpc_lvl = st_r.ctrl[0][tcp_pkg::R0_TPC_BIT];
    end
    st_nxt.od_oe = st_r.ctrl[0][tcp_pkg::R0_TPC_MODE_BIT]
                   & ~st_r.tpc_lvl; // RULE_12

    // RF and PA sequencing
    case (st_r.pa_st)
      tcp_pkg::PA_OFF: begin
        st_nxt.pa_cnt = 16'h0000;
        if (tx_mode) begin
          st_nxt.pa_st = tcp_pkg::PA_SETTLE;
        end
      end
      tcp_pkg::PA_SETTLE: begin
        if (!tx_mode) begin
          st_nxt.pa_st = tcp_pkg::PA_OFF;
        end else if (st_r.pa_cnt >= st_r.settle) begin
          st_nxt.pa_st = tcp_pkg::PA_ON;
        end else begin
          st_nxt.pa_cnt = st_r.pa_cnt + 16'h0001;
        end
      end
      tcp_pkg::PA_ON: begin
        st_nxt.pa_cnt = 16'h0000;
        if (!tx_mode) begin
          st_nxt.pa_st = tcp_pkg::PA_TAIL; // RULE_04
        end
      end
      tcp_pkg::PA_TAIL: begin
        // RF stays up while the PA has already been dropped
        if (st_r.pa_cnt >= 16'(tcp_pkg::PA_LEAD_CYC - 1)) begin // RULE_04
          st_nxt.pa_st  = tcp_pkg::PA_OFF;
          st_nxt.pa_cnt = 16'h0000;
        end else begin
          st_nxt.pa_cnt = st_r.pa_cnt + 16'h0001;
        end
      end
      default: begin
        st_nxt.pa_st = tcp_pkg::PA_OFF;
      end
    endcase
    st_nxt.rf_on = (st_nxt.pa_st == tcp_pkg::PA_ON)
                   | (st_nxt.pa_st == tcp_pkg::PA_TAIL);
    st_nxt.pa_en = (st_nxt.pa_st == tcp_pkg::PA_ON)
                   & ~pa_block; // RULE_04 RULE_05

    // Events: a set in the clearing cycle wins
    st_nxt.ev = (st_r.ev & ~ev_clr) | ev_set;

    // Wishbone slave, one wait cycle, ack for one cycle
    // Ack masks a held strobe so one request never answers twice
    st_nxt.ack = wb_req;
    // Read data is zero except in the ack cycle
    st_nxt.dat = 32'h0000_0000;
    // Settle count is written byte by byte under the lane selects
    if (wb_wr && i_wb_adr == tcp_pkg::WB_CONFIG) begin
      if (i_wb_sel[0]) begin
        st_nxt.settle[7:0] = i_wb_dat[7:0];
      end
      if (i_wb_sel[1]) begin
        st_nxt.settle[15:8] = i_wb_dat[15:8];
      end
    end
    // Read mux; control words are read-only copies of the serial bus
    // Unmapped offsets read as zero and still acknowledge
    if (wb_req && !i_wb_we) begin
      case (i_wb_adr)
        tcp_pkg::WB_CTRL0:  st_nxt.dat = {18'h0, st_r.ctrl[0]};
        tcp_pkg::WB_CTRL1:  st_nxt.dat = {18'h0, st_r.ctrl[1]};
        tcp_pkg::WB_CTRL2:  st_nxt.dat = {18'h0, st_r.ctrl[2]};
        tcp_pkg::WB_CTRL3:  st_nxt.dat = {18'h0, st_r.ctrl[3]};
        tcp_pkg::WB_STATUS: st_nxt.dat = status;
        tcp_pkg::WB_CONFIG: st_nxt.dat = {16'h0000, st_r.settle};
        tcp_pkg::WB_EVENTS: st_nxt.dat = {30'h0, st_r.ev};
        default:            st_nxt.dat = 32'h0000_0000;
      endcase
    end
  end

  // State register; control registers survive standby
  always_ff @(posedge i_mclk or negedge i_nrst) begin // RULE_11
    if (!i_nrst) begin
      st_r         <= '0;
      st_r.ctrl    <= {4{tcp_pkg::CTRL_RST}};
      st_r.tpc_lvl <= tcp_pkg::TPC_LVL_RST;
      st_r.settle  <= tcp_pkg::SETTLE_RST;
      st_r.pa_st   <= tcp_pkg::PA_OFF;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from state flops, except the open-drain data level tied to 0
  // No output passes through logic after its flop
  // The open-drain pin is modelled as enable with a low data level
  assign o_wb_dat           = st_r.dat;
  assign o_wb_ack           = st_r.ack;
  assign o_power_on         = st_r.power_on;
  assign o_rx_active        = st_r.rx_act;
  assign o_tx_active        = st_r.tx_act;
  assign o_tx_mod_bit       = st_r.tx_mod;
  assign o_rf_tx_output_on  = st_r.rf_on;
  assign o_pa_enable_out    = st_r.pa_en;
  assign o_power_ctl_out_o  = 1'b0; // Open drain only pulls low
  assign o_power_ctl_out_oe = st_r.od_oe; // RULE_12
  assign o_rx_data          = st_r.rx_bit;
endmodule
`default_nettype wire

// *** test/tcp_bb_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module tcp_bb_model (
  input  wire logic i_mclk,
  output logic      o_ser_clk,
  output logic      o_ser_data,
  output logic      o_ser_en
);
  // Bus idles with enable high and clock still
  initial begin
    o_ser_clk = 1'b0;
    o_ser_data = 1'b0;
    o_ser_en = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
  endtask

  // Shift n bits MSB first, latch, then optional stray clocks
  task automatic send(input logic [31:0] w, input int n, input logic junk);
    int i;
    @(posedge i_mclk);
    o_ser_en <= 1'b0;
    for (i = n - 1; i >= 0; i--) begin
      o_ser_data <= w[i];
      tick(5);
      o_ser_clk <= 1'b1;
      tick(5);
      o_ser_clk <= 1'b0;
    end
    tick(5);
    o_ser_en <= 1'b1;
    o_ser_data <= ~w[0];
    tick(5);
    // Clock pulses with enable high must be ignored
    if (junk) begin
      repeat (3) begin
        o_ser_clk <= 1'b1;
        o_ser_data <= 1'($urandom);
        tick(5);
        o_ser_clk <= 1'b0;
        tick(5);
      end
    end
    tick(25);
  endtask
endmodule
`default_nettype wire

// *** test/tcp_top_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module tcp_top_asserts #(
  parameter int unsigned DEMOD_W = 8
) (
  input wire logic        i_mclk,
  input wire logic        i_nrst,
  input wire logic        i_wb_cyc,
  input wire logic        i_wb_stb,
  input wire logic        o_wb_ack,
  input wire logic [31:0] o_wb_dat,
  input wire logic        i_transceiver_enable,
  input wire logic        i_rx_tx_select,
  input wire logic        i_tx_data,
  input wire logic        o_power_on,
  input wire logic        o_rx_active,
  input wire logic        o_tx_active,
  input wire logic        o_tx_mod_bit,
  input wire logic        o_rf_tx_output_on,
  input wire logic        o_pa_enable_out,
  input wire logic        o_power_ctl_out_o,
  input wire logic        o_power_ctl_out_oe,
  input wire logic        o_rx_data
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);

  logic [10:0] gap_r;
  // Counts RF-on cycles since the PA enable was last high
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst)
      gap_r <= '0;
    else if (o_pa_enable_out)
      gap_r <= '0;
    else if (o_rf_tx_output_on && gap_r != 11'h7ff)
      gap_r <= gap_r + 11'h1;
  end

  sequence s_off;
    (!i_transceiver_enable) [*6];
  endsequence
  sequence s_rx_held;
    (i_transceiver_enable && i_rx_tx_select) [*6];
  endsequence
  sequence s_tx_held;
    (i_transceiver_enable && !i_rx_tx_select) [*6];
  endsequence

  property p_wb_ack;
    i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack;
  endproperty
  a_wb_ack: assert property (p_wb_ack) else $error("wb ack timing");
  property p_wb_idle;
    !o_wb_ack |-> o_wb_dat == 32'h0;
  endproperty
  a_wb_idle: assert property (p_wb_idle) else $error("wb data not idle");
  property p_standby;
    s_off |-> !o_power_on && !o_rx_active && !o_tx_active;
  endproperty
  a_standby: assert property (p_standby) else $error("standby");
  property p_rx_mode;
    s_rx_held |-> o_rx_active && o_power_on;
  endproperty
  a_rx_mode: assert property (p_rx_mode) else $error("rx mode");
  property p_tx_mode;
    s_tx_held |-> o_tx_active && !o_rx_active;
  endproperty
  a_tx_mode: assert property (p_tx_mode) else $error("tx mode");
  property p_pa_rf;
    o_pa_enable_out |-> o_rf_tx_output_on;
  endproperty
  a_pa_rf: assert property (p_pa_rf) else $error("pa without rf");
  property p_pa_drop;
    $fell(o_tx_active) |-> ##[0:1] !o_pa_enable_out;
  endproperty
  a_pa_drop: assert property (p_pa_drop) else $error("pa late");
  property p_rf_tail;
    $fell(o_rf_tx_output_on) |-> gap_r >= tcp_pkg::PA_LEAD_CYC;
  endproperty
  a_rf_tail: assert property (p_rf_tail) else $error("rf tail");
  property p_od;
    o_power_ctl_out_oe |-> !o_power_ctl_out_o;
  endproperty
  a_od: assert property (p_od) else $error("open drain high");
  property p_txbit;
    (o_tx_active && i_tx_data) [*5] |-> o_tx_mod_bit;
  endproperty
  a_txbit: assert property (p_txbit) else $error("tx bit");
  property p_rxbit;
    (!o_rx_active) [*3] |-> !o_rx_data;
  endproperty
  a_rxbit: assert property (p_rxbit) else $error("rx data");
endmodule

bind tcp_top tcp_top_asserts #(.DEMOD_W(DEMOD_W)) u_asserts (
  .i_mclk(i_mclk), .i_nrst(i_nrst), .i_wb_cyc(i_wb_cyc),
  .i_wb_stb(i_wb_stb), .o_wb_ack(o_wb_ack), .o_wb_dat(o_wb_dat),
  .i_transceiver_enable(i_transceiver_enable),
  .i_rx_tx_select(i_rx_tx_select), .i_tx_data(i_tx_data),
  .o_power_on(o_power_on), .o_rx_active(o_rx_active),
  .o_tx_active(o_tx_active), .o_tx_mod_bit(o_tx_mod_bit),
  .o_rf_tx_output_on(o_rf_tx_output_on),
  .o_pa_enable_out(o_pa_enable_out),
  .o_power_ctl_out_o(o_power_ctl_out_o),
  .o_power_ctl_out_oe(o_power_ctl_out_oe), .o_rx_data(o_rx_data)
);
`default_nettype wire

// *** test/tcp_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tcp_tb_top;
  logic        clk, rst_n, req, we, en, sel, tx, lock, ack;
  logic        sclk, sdat, sen, pwr, rxa, txa, mb, rf, pa, po, poe, rxd;
  logic [7:0]  adr, dm;
  logic [31:0] wd, q, rd;
  logic [13:0] v [4];
  int          num_errors, n_checks, i, k;

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  tcp_top dut (
    .i_mclk(clk), .i_nrst(rst_n), .i_wb_cyc(req), .i_wb_stb(req),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wd), .i_wb_sel(4'hf),
    .o_wb_dat(q), .o_wb_ack(ack), .i_transceiver_enable(en),
    .i_rx_tx_select(sel), .i_ser_clk(sclk), .i_ser_data(sdat),
    .i_ser_en(sen), .i_tx_data(tx), .i_pll_lock(lock), .i_demod(dm),
    .o_power_on(pwr), .o_rx_active(rxa), .o_tx_active(txa),
    .o_tx_mod_bit(mb), .o_rf_tx_output_on(rf), .o_pa_enable_out(pa),
    .o_power_ctl_out_o(po), .o_power_ctl_out_oe(poe), .o_rx_data(rxd));
  tcp_bb_model bb (.i_mclk(clk), .o_ser_clk(sclk), .o_ser_data(sdat),
    .o_ser_en(sen));

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      num_errors++;
    end
  endtask

  // One classic Wishbone cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    req <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    for (n = 0; n < 20 && ack !== 1'b1; n++)
      @(posedge clk);
    rd = q;
    req <= 1'b0;
    if (n >= 20)
      num_errors++;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  task automatic mode(input logic e, input logic s);
    @(posedge clk);
    en <= e;
    sel <= s;
    repeat (8) @(posedge clk);
  endtask

  task automatic r0(input logic [13:0] d);
    bb.send({18'h0, d}, 16, 1'b0);
    repeat (10) @(posedge clk);
  endtask

  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    #400000;
    num_errors++;
    stop_test;
  end

  initial begin
    rst_n = 1'b0;
    req = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    wd = 32'h0;
    en = 1'b0;
    sel = 1'b1;
    tx = 1'b0;
    lock = 1'b0;
    dm = 8'h00;
    num_errors = 0;
    n_checks = 0;
    i = $urandom(32'ha946);
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rc(8'h10, 32'h40);
    rc(8'h14, 32'h10);
    wb(1'b1, 8'h1c, 32'hffffffff);
    rc(8'h1c, 32'h0);
    $display("reset test done");
    // Words of growing length written in standby
    for (k = 0; k < 4; k++) begin
      v[k] = 14'($urandom);
      bb.send({12'($urandom), 2'(k), v[k]}, 16 + 4 * k, 1'b1);
      repeat (10) @(posedge clk);
      wb(1'b0, 8'h18, 32'h0);
      chk(rd & 32'h2, 32'h2);
      wb(1'b1, 8'h18, 32'h2);
    end
    rc(8'h18, 32'h0);
    for (k = 0; k < 4; k++)
      rc(8'(4 * k), {18'h0, v[k]});
    $display("serial test done");
    mode(1'b1, 1'b1);
    rc(8'h10, 32'h43);
    for (i = 0; i < 200; i++) begin
      @(posedge clk);
      dm <= 8'($urandom);
    end
    @(posedge clk);
    dm <= 8'h80;
    repeat (500) @(posedge clk);
    wb(1'b0, 8'h18, 32'h0);
    chk(rd & 32'h1, 32'h1);
    $display("receive test done");
    lock <= 1'b1;
    mode(1'b1, 1'b0);
    for (k = 0; k < 200 && pa !== 1'b1; k++)
      @(posedge clk);
    chk({rf, pa}, 2'b11);
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      tx <= 1'($urandom);
      repeat (5) @(posedge clk);
      chk(mb, tx);
    end
    @(posedge clk);
    sel <= 1'b1;
    for (k = 0, i = 0; i < 3000 && rf !== 1'b0; i++) begin
      @(posedge clk);
      if (rf === 1'b1 && pa === 1'b0)
        k++;
    end
    chk(32'(k), tcp_pkg::PA_LEAD_CYC);
    $display("transmit test done");
    r0(14'h100);
    @(posedge clk);
    lock <= 1'b0;
    mode(1'b1, 1'b0);
    repeat (40) @(posedge clk);
    chk({rf, pa}, 2'b10);
    mode(1'b1, 1'b1);
    r0(14'h0c0);
    chk(poe, 1'b1);
    mode(1'b1, 1'b0);
    chk(poe, 1'b0);
    mode(1'b1, 1'b1);
    r0(14'h040);
    chk(poe, 1'b0);
    mode(1'b1, 1'b0);
    chk({po, poe}, 2'b01);
    $display("power control test done");
    mode(1'b0, 1'b1);
    chk({pwr, rxa, txa, rxd}, 4'b0000);
    rc(8'h04, {18'h0, v[1]});
    $display("standby test done");
    stop_test;
  end
endmodule
`default_nettype wire
